// file: core/oscmc_pkg.sv
/*
 holds the constants and carrier types of the oscillator and operating-mode controller.
 assumes a 200 MHz MCLK domain that counts oscillator periods as enable pulses.
*/
package oscmc_pkg;
   // ==========================================================
   // register map (byte addresses, only byte lane 0 carries data)
   // ==========================================================
   localparam logic [7:0] OSC_MODE_ADDR = 8'hCA;
   localparam logic [7:0] P1_WAKE_ADDR = 8'hC0;
   localparam logic [7:0] OSC_MODE_RESET = 8'h00;
   localparam logic [7:0] P1_WAKE_RESET = 8'h00;
   localparam int HIGH_STOP_BIT = 1;
   localparam int CLK_SLOW_BIT = 2;
   localparam int POWER_DOWN_BIT = 3;
   localparam int GREEN_BIT = 4;
   localparam logic [7:0] OSC_MODE_WMASK = 8'h1E;
   // ==========================================================
   // operating-mode field codes
   // ==========================================================
   localparam logic [1:0] OPMODE_NORMAL = 2'h0;
   localparam logic [1:0] OPMODE_SLEEP = 2'h1;
   localparam logic [1:0] OPMODE_GREEN = 2'h2;
   localparam logic [1:0] OPMODE_RSVD = 2'h3;
   // ==========================================================
   // timing counts in oscillator periods, and the counter width in bits
   // ==========================================================
   localparam int CFG_LOW_PERIODS = 2048;
   localparam int WARM_RESET_PERIODS = 2048;
   localparam int WARM_WAKE_PERIODS = 32;
   localparam int SLOW_CPU_DIV = 4;
   localparam int CNT_W = 12;

   typedef enum logic [5:0]
   {
      ST_CONFIG = 6'h01,
      ST_WARM = 6'h02,
      ST_RUN = 6'h04,
      ST_GREEN = 6'h08,
      ST_SLEEP = 6'h10,
      ST_WAKE = 6'h20
   } oscmc_state_t;

   typedef struct packed
   {
      logic high_osc_run;
      logic low_osc_run;
      logic sys_clk_slow;
      logic cpu_run;
      logic timers_run;
   } oscmc_clk_ctrl_t;
endpackage

// file: core/oscmc_top.sv
/*
 oscillator and operating-mode controller: mode sequencing, oscillator gating,
 clock-source selection and warm-up counting.
 assumes the two oscillators are presented as one-MCLK-cycle period ticks,
 that all inputs are synchronous to MCLK, and an Avalon-MM slave at byte addresses.
*/
// Overview of operation
// - slow mode instruction rate is low/4
// - mode register at 0CAH, zero reset
// - stop bit halts high-speed oscillator only
// - clock select picks low-speed system clock
// - mode field: normal, sleep, green, reserved
// - low oscillator stops: sleep, green-slow-no-watchdog
// - no separate low oscillator off control
// - wait 2048 low periods at power-up
// - reset warm-up 2048 high periods
// - sleep wake-up waits 32 high periods
// - oscillators and execution follow mode table
// - timers follow enables, off in sleep
// - wake sources differ for green, sleep
// - after reset enter normal and execute
// - sleep wake-up always returns to normal
// - green wake-up returns to prior mode
// - slow mode leaves high oscillator running
// - sleep bit cleared by hardware on wake
// - sleep stops oscillators and execution
// - stop bit in normal acts as sleep
// - port 0 always wakes, port 1 masked
// - either pin edge triggers wake-up
// - green bit cleared by hardware on wake
// - green wake-up has no warm-up
module oscmc_top
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic HIGH_OSC_TICK,
   input wire logic LOW_OSC_TICK,
   input wire logic WATCHDOG_ENABLE,
   input wire logic [7:0] PORT0_IN,
   input wire logic [7:0] PORT1_IN,
   input wire logic BASIC_TIMER_OVERFLOW,
   input wire logic COMPARATOR_EVENT,
   input wire logic [3:0] TIMER_ENABLES,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic HIGH_OSC_ENABLE,
   output logic LOW_OSC_ENABLE,
   output logic SYS_CLK_SLOW,
   output logic CPU_TICK,
   output logic CPU_RUN,
   output logic [3:0] TIMER_RUN,
   output logic [5:0] MODE_STATE
);
   // ==========================================================
   // state
   // ==========================================================
   oscmc_pkg::oscmc_state_t state_q;
   logic [7:0] osc_mode_q;
   logic [7:0] p1_wake_q;
   logic [7:0] port0_q;
   logic [7:0] port1_q;
   logic [oscmc_pkg::CNT_W-1:0] cnt_q;
   logic [1:0] div_q;
   logic sel_slow_q;
   logic ack_q;
   oscmc_pkg::oscmc_clk_ctrl_t ctrl_q;

   logic high_stop;
   logic clk_slow;
   logic [1:0] mode_field;
   logic pin_change;
   logic green_wake;
   logic sys_tick;
   logic bus_req;
   logic mode_wr;
   logic wake_wr;

   function automatic logic [7:0] lane0(input logic [31:0] data);
      lane0 = data[7:0];
   endfunction

   assign high_stop = osc_mode_q[oscmc_pkg::HIGH_STOP_BIT];
   assign clk_slow = osc_mode_q[oscmc_pkg::CLK_SLOW_BIT];
   assign mode_field = osc_mode_q[oscmc_pkg::GREEN_BIT:oscmc_pkg::POWER_DOWN_BIT];

   // ==========================================================
   // bus slave: one wait cycle, then answer
   // ==========================================================
   // a write lands on the first request edge; a held request is never withdrawn
   assign bus_req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req & ~ack_q;
   assign mode_wr = AVS_WRITE & ~ack_q & AVS_BYTEENABLE[0]
                    & (AVS_ADDRESS == oscmc_pkg::OSC_MODE_ADDR);
   assign wake_wr = AVS_WRITE & ~ack_q & AVS_BYTEENABLE[0]
                    & (AVS_ADDRESS == oscmc_pkg::P1_WAKE_ADDR);

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ack_q <= 1'b0;
      else
         ack_q <= bus_req & ~ack_q;
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         AVS_READDATA <= 32'h00000000;
      else if (AVS_READ & ~ack_q)
      begin
         if (AVS_ADDRESS == oscmc_pkg::OSC_MODE_ADDR)
            AVS_READDATA <= {24'h000000, osc_mode_q & oscmc_pkg::OSC_MODE_WMASK};
         else
            AVS_READDATA <= 32'h00000000;
      end
   end

   // ==========================================================
   // wake detection
   // ==========================================================
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         port0_q <= 8'h00;
         port1_q <= 8'h00;
      end
      else
      begin
         port0_q <= PORT0_IN;
         port1_q <= PORT1_IN;
      end
   end

   // a false change right after reset is harmless: start-up states ignore wake-up
   // a level change on any port 0 pin or on a port 1 pin enabled in p1_wake_q
   assign pin_change = |(port0_q ^ PORT0_IN) | |((port1_q ^ PORT1_IN) & p1_wake_q);
   // green takes timer and comparator too
   assign green_wake = pin_change | BASIC_TIMER_OVERFLOW | COMPARATOR_EVENT;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         p1_wake_q <= oscmc_pkg::P1_WAKE_RESET;
      else if (wake_wr)
         p1_wake_q <= lane0(AVS_WRITEDATA);
   end

   // ==========================================================
   // mode register: hardware clear beats software write
   // ==========================================================
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         osc_mode_q <= oscmc_pkg::OSC_MODE_RESET;
      else if (state_q == oscmc_pkg::ST_SLEEP && pin_change)
      begin
         osc_mode_q[oscmc_pkg::POWER_DOWN_BIT] <= 1'b0;
         osc_mode_q[oscmc_pkg::CLK_SLOW_BIT] <= 1'b0;
         osc_mode_q[oscmc_pkg::HIGH_STOP_BIT] <= 1'b0;
      end
      else if (state_q == oscmc_pkg::ST_GREEN && green_wake)
         // clock select kept, prior mode restored
         osc_mode_q[oscmc_pkg::GREEN_BIT] <= 1'b0;
      // a wake clear cannot meet a real write: execution is halted in sleep and green
      else if (mode_wr)
         osc_mode_q <= lane0(AVS_WRITEDATA) & oscmc_pkg::OSC_MODE_WMASK;
   end

   // ==========================================================
   // sequencer
   // ==========================================================
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         state_q <= oscmc_pkg::ST_CONFIG;
         cnt_q <= '0;
      end
      else
      begin
         unique case (state_q)
            oscmc_pkg::ST_CONFIG:
            begin
               if (LOW_OSC_TICK)
               begin
                  if (cnt_q == oscmc_pkg::CNT_W'(oscmc_pkg::CFG_LOW_PERIODS - 1))
                  begin
                     cnt_q <= '0;
                     state_q <= oscmc_pkg::ST_WARM;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               end
            end
            oscmc_pkg::ST_WARM:
            begin
               if (HIGH_OSC_TICK)
               begin
                  if (cnt_q == oscmc_pkg::CNT_W'(oscmc_pkg::WARM_RESET_PERIODS - 1))
                  begin
                     cnt_q <= '0;
                     state_q <= oscmc_pkg::ST_RUN;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               end
            end
            oscmc_pkg::ST_RUN:
            begin
               // field decode picks the next mode
               if (mode_field == oscmc_pkg::OPMODE_SLEEP)
                  state_q <= oscmc_pkg::ST_SLEEP;
               else if (mode_field == oscmc_pkg::OPMODE_GREEN)
                  state_q <= oscmc_pkg::ST_GREEN;
               // no clock left acts as sleep
               else if (high_stop && !clk_slow)
                  state_q <= oscmc_pkg::ST_SLEEP;
            end
            oscmc_pkg::ST_GREEN:
            begin
               if (green_wake)
                  state_q <= oscmc_pkg::ST_RUN;
            end
            oscmc_pkg::ST_SLEEP:
            begin
               if (pin_change)
               begin
                  cnt_q <= '0;
                  state_q <= oscmc_pkg::ST_WAKE;
               end
            end
            oscmc_pkg::ST_WAKE:
            begin
               if (HIGH_OSC_TICK)
               begin
                  if (cnt_q == oscmc_pkg::CNT_W'(oscmc_pkg::WARM_WAKE_PERIODS - 1))
                  begin
                     cnt_q <= '0;
                     state_q <= oscmc_pkg::ST_RUN;
                  end
                  else
                     cnt_q <= cnt_q + 1'b1;
               end
            end
            default:
               state_q <= oscmc_pkg::ST_CONFIG;
         endcase
      end
   end

   // ==========================================================
   // oscillator and clock control
   // ==========================================================
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ctrl_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      else
      begin
         // slow select alone leaves it on
         ctrl_q.high_osc_run <= (state_q != oscmc_pkg::ST_SLEEP)
            & ~(state_q inside {oscmc_pkg::ST_RUN, oscmc_pkg::ST_GREEN} & high_stop);
         ctrl_q.low_osc_run <= (state_q != oscmc_pkg::ST_SLEEP)
            & ~(state_q == oscmc_pkg::ST_GREEN & clk_slow & ~WATCHDOG_ENABLE);
         // execution in normal and slow only
         ctrl_q.cpu_run <= (state_q == oscmc_pkg::ST_RUN);
         // timers off in sleep and start-up
         ctrl_q.timers_run <= state_q inside {oscmc_pkg::ST_RUN, oscmc_pkg::ST_GREEN};
         // change source only on a low tick edge
         ctrl_q.sys_clk_slow <= sel_slow_q;
      end
   end

   // source swap waits for a low-oscillator period boundary
   // limitation: the swap may lag the select bit by up to four low periods
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         sel_slow_q <= 1'b0;
      else if (LOW_OSC_TICK && div_q == 2'h0)
         sel_slow_q <= clk_slow;
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         div_q <= 2'h0;
      else if (LOW_OSC_TICK)
         div_q <= 2'(div_q + 2'h1);
   end

   assign sys_tick = sel_slow_q ? (LOW_OSC_TICK & (div_q == 2'(oscmc_pkg::SLOW_CPU_DIV - 1)))
                                : HIGH_OSC_TICK;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         CPU_TICK <= 1'b0;
      else
         CPU_TICK <= sys_tick & (state_q == oscmc_pkg::ST_RUN);
   end

   // each timer follows its own enable
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         TIMER_RUN <= 4'h0;
      else
         TIMER_RUN <= TIMER_ENABLES & {4{ctrl_q.timers_run}};
   end

   assign HIGH_OSC_ENABLE = ctrl_q.high_osc_run;
   assign LOW_OSC_ENABLE = ctrl_q.low_osc_run;
   assign SYS_CLK_SLOW = ctrl_q.sys_clk_slow;
   assign CPU_RUN = ctrl_q.cpu_run;
   assign MODE_STATE = state_q;
endmodule

// file: testbench/oscmc_top_chk.sv
/*
 port assertions for the oscillator and operating-mode controller.
 assumes oscillator ticks come at most once per MCLK and a master that holds its requests.
*/
module oscmc_top_chk
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic HIGH_OSC_TICK,
   input wire logic [7:0] PORT0_IN,
   input wire logic [7:0] PORT1_IN,
   input wire logic BASIC_TIMER_OVERFLOW,
   input wire logic [3:0] TIMER_ENABLES,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic HIGH_OSC_ENABLE,
   input wire logic LOW_OSC_ENABLE,
   input wire logic SYS_CLK_SLOW,
   input wire logic CPU_TICK,
   input wire logic CPU_RUN,
   input wire logic [3:0] TIMER_RUN,
   input wire logic [5:0] MODE_STATE
);
   // ==========================================================
   // high ticks seen during sleep wake-up
   // ==========================================================
   logic [5:0] hcnt_q;
   always_ff @(posedge MCLK or posedge RESET)
      if (RESET)
         hcnt_q <= 6'h00;
      else if (MODE_STATE != 6'h20)
         hcnt_q <= 6'h00;
      else if (HIGH_OSC_TICK && hcnt_q != 6'h3F)
         hcnt_q <= hcnt_q + 6'h01;
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (RESET);
   // ==========================================================
   // assertions
   // ==========================================================
   bus_wait_a: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered after one wait cycle");
   read_zero_a: assert property (
      AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:5] == 27'h0000000 && !AVS_READDATA[0])
      else $error("unused read bits not zero");
   cpu_halt_a: assert property ($past(MODE_STATE) != 6'h04 |-> !CPU_RUN)
      else $error("execution outside run state");
   // timer gating lags the state by two registers, so sleep must have stood three samples
   sleep_off_a: assert property (
      MODE_STATE == 6'h10 && $past(MODE_STATE) == 6'h10 && $past(MODE_STATE, 2) == 6'h10
      |-> !HIGH_OSC_ENABLE && !LOW_OSC_ENABLE && TIMER_RUN == 4'h0)
      else $error("oscillator or timer alive in sleep");
   timers_follow_a: assert property (
      MODE_STATE inside {6'h04, 6'h08} && $past(MODE_STATE, 2) inside {6'h04, 6'h08}
      && $stable(MODE_STATE) && $stable(TIMER_ENABLES) |-> TIMER_RUN == TIMER_ENABLES)
      else $error("timer run differs from enables");
   wake_delay_a: assert property (
      MODE_STATE == 6'h20 && hcnt_q < 6'h1F |=> MODE_STATE != 6'h04)
      else $error("sleep wake-up shorter than warm-up");
   green_wake_a: assert property (
      MODE_STATE == 6'h08 && BASIC_TIMER_OVERFLOW |=> MODE_STATE == 6'h04)
      else $error("green mode missed timer wake-up");
   sleep_hold_a: assert property (
      MODE_STATE == 6'h10 && $stable(PORT0_IN) && $stable(PORT1_IN) |=> MODE_STATE == 6'h10)
      else $error("sleep left without pin change");
   slow_div_a: assert property (
      CPU_TICK && SYS_CLK_SLOW && $past(SYS_CLK_SLOW) |=> !CPU_TICK [*3])
      else $error("slow instruction ticks too close");
   green_seen_c: cover property (MODE_STATE == 6'h08 ##1 MODE_STATE == 6'h04);
   sleep_seen_c: cover property (MODE_STATE == 6'h10 ##1 MODE_STATE == 6'h20);
   read_seen_c: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule

bind oscmc_top oscmc_top_chk i_oscmc_top_chk (.MCLK(MCLK), .RESET(RESET),
   .HIGH_OSC_TICK(HIGH_OSC_TICK), .PORT0_IN(PORT0_IN), .PORT1_IN(PORT1_IN),
   .BASIC_TIMER_OVERFLOW(BASIC_TIMER_OVERFLOW), .TIMER_ENABLES(TIMER_ENABLES),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .HIGH_OSC_ENABLE(HIGH_OSC_ENABLE),
   .LOW_OSC_ENABLE(LOW_OSC_ENABLE), .SYS_CLK_SLOW(SYS_CLK_SLOW), .CPU_TICK(CPU_TICK),
   .CPU_RUN(CPU_RUN), .TIMER_RUN(TIMER_RUN), .MODE_STATE(MODE_STATE));

// file: testbench/oscmc_top_test.sv
/*
 self-checking bench for the oscillator and operating-mode controller.
 assumes the design alone, with oscillator ticks made here from MCLK.
*/
module oscmc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'b0, RESET = 1'b1, HIGH_OSC_TICK = 1'b0, LOW_OSC_TICK = 1'b0;
   logic WATCHDOG_ENABLE = 1'b0, BASIC_TIMER_OVERFLOW = 1'b0, COMPARATOR_EVENT = 1'b0;
   logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [7:0] PORT0_IN = 8'h00, PORT1_IN = 8'h00, AVS_ADDRESS = 8'h00;
   logic [3:0] TIMER_ENABLES = 4'h0, AVS_BYTEENABLE = 4'hF, TIMER_RUN;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic AVS_WAITREQUEST, HIGH_OSC_ENABLE, LOW_OSC_ENABLE, SYS_CLK_SLOW, CPU_TICK, CPU_RUN;
   logic [5:0] MODE_STATE;
   logic [1:0] tcnt = 2'h0;
   logic [31:0] exp_q[$];
   int num_errors = 0, cmp_count = 0, waited = 0, ticks = 0;
   oscmc_top i_oscmc_top (.MCLK(MCLK), .RESET(RESET), .HIGH_OSC_TICK(HIGH_OSC_TICK),
      .LOW_OSC_TICK(LOW_OSC_TICK), .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .PORT0_IN(PORT0_IN),
      .PORT1_IN(PORT1_IN), .BASIC_TIMER_OVERFLOW(BASIC_TIMER_OVERFLOW),
      .COMPARATOR_EVENT(COMPARATOR_EVENT), .TIMER_ENABLES(TIMER_ENABLES),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .HIGH_OSC_ENABLE(HIGH_OSC_ENABLE), .LOW_OSC_ENABLE(LOW_OSC_ENABLE),
      .SYS_CLK_SLOW(SYS_CLK_SLOW), .CPU_TICK(CPU_TICK), .CPU_RUN(CPU_RUN),
      .TIMER_RUN(TIMER_RUN), .MODE_STATE(MODE_STATE));
   // ==========================================================
   // clock and oscillator ticks: high every 2nd, low every 4th cycle
   // ==========================================================
   always #2.5 MCLK = ~MCLK;
   always @(posedge MCLK)
   begin
      tcnt <= tcnt + 2'h1;
      HIGH_OSC_TICK <= tcnt[0];
      LOW_OSC_TICK <= (tcnt == 2'h3);
   end
   // ==========================================================
   // compare, verdict, bus and wait tasks
   // ==========================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one request held until waitrequest is sampled low, then released for one edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      logic [31:0] r;
      int n;
      r = $urandom();
      n = 0;
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= {r[31:8], d};
      AVS_BYTEENABLE <= be;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 20);
      // judge the timeout on the answer itself, so a late but valid answer still counts
      if (AVS_WAITREQUEST !== 1'b0)
      begin
         num_errors++;
         tally_and_finish();
      end
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({24'h000000, e});
      bus(1'b0, a, 8'h00, 4'hF);
   endtask
   task automatic wait_state(input logic [5:0] s, input int lim);
      waited = 0;
      while (MODE_STATE !== s && waited < lim)
      begin
         @(posedge MCLK);
         waited++;
      end
      if (MODE_STATE !== s)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic pulse_wake(input logic cmp);
      BASIC_TIMER_OVERFLOW <= !cmp;
      COMPARATOR_EVENT <= cmp;
      @(posedge MCLK);
      BASIC_TIMER_OVERFLOW <= 1'b0;
      COMPARATOR_EVENT <= 1'b0;
   endtask
   // read data is judged in the cycle it stands, against the oldest note
   always @(posedge MCLK)
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
         chk(AVS_READDATA, exp_q.pop_front(), "readdata");
   // ==========================================================
   // main sequence
   // ==========================================================
   initial
   begin
      logic [7:0] gmode [3];
      gmode = '{8'h16, 8'h16, 8'h10};
      void'($urandom(32'h04820504));
      @(posedge MCLK);
      PORT0_IN <= 8'($urandom());
      PORT1_IN <= 8'($urandom());
      TIMER_ENABLES <= 4'($urandom());
      repeat (19) @(posedge MCLK);
      chk(MODE_STATE, 6'h01, "reset state");
      RESET <= 1'b0;
      wait_state(6'h04, 13000);
      chk(32'(waited >= 12200), 32'h1, "startup time");
      rd(oscmc_pkg::OSC_MODE_ADDR, 8'h00);
      rd(oscmc_pkg::P1_WAKE_ADDR, 8'h00);
      rd(8'h44, 8'h00);
      bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'hFD, 4'hF);
      bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'h1E, 4'hE);
      rd(oscmc_pkg::OSC_MODE_ADDR, 8'h1C);
      chk(MODE_STATE, 6'h04, "reserved code state");
      bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'h04, 4'hF);
      repeat (40) @(posedge MCLK);
      chk({HIGH_OSC_ENABLE, SYS_CLK_SLOW, CPU_RUN}, 3'h7, "slow mode");
      ticks = 0;
      repeat (160)
      begin
         @(posedge MCLK);
         if (CPU_TICK === 1'b1)
            ticks++;
      end
      chk(ticks, 32'h0000000A, "slow tick count");
      bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'h06, 4'hF);
      repeat (8) @(posedge MCLK);
      chk({HIGH_OSC_ENABLE, LOW_OSC_ENABLE, MODE_STATE}, 8'h44, "stop in slow");
      for (int i = 0; i < 3; i++)
      begin
         WATCHDOG_ENABLE <= (i == 1);
         bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, gmode[i], 4'hF);
         wait_state(6'h08, 4);
         repeat (2) @(posedge MCLK);
         chk({CPU_RUN, LOW_OSC_ENABLE}, {1'b0, i != 0}, "green osc");
         chk(TIMER_RUN, TIMER_ENABLES, "green timers");
         pulse_wake(i == 2);
         wait_state(6'h04, 2);
         rd(oscmc_pkg::OSC_MODE_ADDR, gmode[i] & 8'h06);
      end
      bus(1'b1, oscmc_pkg::P1_WAKE_ADDR, 8'h01, 4'hF);
      bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'h0C, 4'hF);
      wait_state(6'h10, 4);
      repeat (2) @(posedge MCLK);
      chk({HIGH_OSC_ENABLE, LOW_OSC_ENABLE, CPU_RUN, TIMER_RUN}, 7'h00, "sleep");
      PORT1_IN <= PORT1_IN ^ 8'h02;
      pulse_wake(1'b0);
      pulse_wake(1'b1);
      repeat (3) @(posedge MCLK);
      chk(MODE_STATE, 6'h10, "sleep ignores");
      PORT1_IN <= PORT1_IN ^ 8'h01;
      wait_state(6'h20, 4);
      wait_state(6'h04, 200);
      chk(32'(waited >= 60), 32'h1, "wake time");
      rd(oscmc_pkg::OSC_MODE_ADDR, 8'h00);
      // both edges of one port 0 pin wake the stop-in-normal state
      for (int i = 0; i < 2; i++)
      begin
         bus(1'b1, oscmc_pkg::OSC_MODE_ADDR, 8'h02, 4'hF);
         wait_state(6'h10, 4);
         PORT0_IN <= PORT0_IN ^ 8'h80;
         wait_state(6'h20, 4);
         wait_state(6'h04, 200);
      end
      chk(SYS_CLK_SLOW, 1'b0, "normal after wake");
      tally_and_finish();
   end
endmodule
